// >>> src/iapfp_ctrl.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Function
// - Software cannot set erase/write enabled
// - Clearing enabled bit disables erase/write
// - Enabled set only by successful unlock
// - Decode write, erase, read, unlock modes
// - Trigger starts unlock timer, clears on expiry
// - Write initiate launches, clears when done
// - Reads only while read enable set
// - Read initiate launches, clears when done
// - Stall CPU during read, write, erase
// - Pattern 55H resets whole chip
// - Duration select picks erase/write times
// - Buffer clear bit clears, self-clears
// - Thirteen-bit address, upper bits read zero
// - Low byte write stores only
// - High byte write loads word, increments
// - Increment stops at page last word
// - Unlock needs six byte pattern in window
// - Buffer cleared after write completes
module iapfp_ctrl
   import iapfp_pkg::*;
#(
   parameter int ERASE0_CYCLES = ERASE0_CYC,
   parameter int ERASE1_CYCLES = ERASE1_CYC,
   parameter int WRITE0_CYCLES = WRITE0_CYC,
   parameter int WRITE1_CYCLES = WRITE1_CYC,
   parameter int READ_CYCLES   = READ_CYC,
   parameter int UNLOCK_CYCLES = UNLOCK_CYC
) (
   // Clock, reset, enable
   input  wire logic              core_clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              ce_i,
   // Special register port
   input  wire logic [3:0]        reg_addr_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   input  wire logic [7:0]        reg_wdata_i,
   output logic      [7:0]        reg_rdata_o,
   // Flash array
   output logic                   fl_erase_o,
   output logic                   fl_prog_o,
   output logic                   fl_read_o,
   output logic      [ADDR_W-1:0] fl_addr_o,
   output logic      [15:0]       fl_wdata_o,
   input  wire logic [15:0]       fl_rdata_i,
   // System
   output logic                   cpu_stall_o,
   output logic                   chip_rst_o
);

   ////////////////////////////////////////////////////////////////////////////////
   logic                  erase_write_enabled_r;
   logic [2:0]            operation_mode_select_r;
   logic                  unlock_trigger_r;
   logic                  write_initiate_r;
   logic                  read_enable_r;
   logic                  read_initiate_r;
   logic                  duration_select_r;
   logic                  buffer_clear_r;
   logic [7:0]            chip_reset_pattern_r;
   logic [ADDR_W-1:0]     flash_word_address_r;
   logic [7:0]            data_r [8];
   logic [15:0]           wbuf_r [PAGE_WORDS];
   logic [PAGE_WORDS-1:0] tag_r;
   logic [5:0]            unlk_match_r;
   logic [4:0]            stream_idx_r;
   logic                  stream_on_r;
   iapfp_state_type       state_r;

   logic                  wr_fc0;
   logic                  wr_fc2;
   logic                  wr_hi0;
   logic                  launch_ew;
   logic                  launch_rd;
   logic                  unlk_start;
   logic                  unlk_run;
   logic                  unlk_expire;
   logic                  op_start;
   logic [OP_CNT_W-1:0]   op_len;
   logic                  op_expire;
   logic                  unlock_ok;
   logic [2:0]            new_mode;
   logic                  idle;

   assign idle     = (state_r == ST_IDLE);
   assign wr_fc0   = reg_wr_i && idle && (reg_addr_i == REG_FLASH_OP_CONTROL);
   assign wr_fc2   = reg_wr_i && idle && (reg_addr_i == REG_FLASH_TIMING);
   assign wr_hi0   = reg_wr_i && idle && (reg_addr_i == REG_WORD0_DATA_HIGH);
   assign new_mode = reg_wdata_i[FC0_MODE_HI:FC0_MODE_LO];

   // Erase/write only once unlocked and mode decodes to write or erase
   assign launch_ew = wr_fc0 && reg_wdata_i[FC0_WI_BIT] && erase_write_enabled_r
                      && ((new_mode == MODE_WRITE) || (new_mode == MODE_ERASE));
   // Read enable must already be set; the same write may not set both
   assign launch_rd = wr_fc0 && reg_wdata_i[FC0_RI_BIT] && read_enable_r
                      && (new_mode == MODE_READ);
   assign unlk_start = wr_fc0 && reg_wdata_i[FC0_TRIG_BIT] && (new_mode == MODE_UNLOCK);
   assign unlock_ok  = unlk_run && (&unlk_match_r);
   assign op_start   = launch_ew || launch_rd;

   always_comb begin
      if (launch_rd) begin
         op_len = OP_CNT_W'(READ_CYCLES);
      end else if (new_mode == MODE_ERASE) begin
         op_len = duration_select_r ? OP_CNT_W'(ERASE1_CYCLES)
                                    : OP_CNT_W'(ERASE0_CYCLES);
      end else begin
         op_len = duration_select_r ? OP_CNT_W'(WRITE1_CYCLES)
                                    : OP_CNT_W'(WRITE0_CYCLES);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   iapfp_timer #(.W(UNLK_CNT_W)) u_unlock_timer (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (ce_i),
      .start_i    (unlk_start),
      .len_i      (UNLK_CNT_W'(UNLOCK_CYCLES)),
      .run_o      (unlk_run),
      .expire_o   (unlk_expire)
   );

   iapfp_timer #(.W(OP_CNT_W)) u_op_timer (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (ce_i),
      .start_i    (op_start),
      .len_i      (op_len),
      .run_o      (),
      .expire_o   (op_expire)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Operation sequencer
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= ST_IDLE;
      end else if (ce_i) begin
         unique case (state_r)
            ST_IDLE: begin
               if (launch_rd) begin
                  state_r <= ST_READ;
               end else if (launch_ew) begin
                  state_r <= (new_mode == MODE_ERASE) ? ST_ERASE : ST_WRITE;
               end
            end
            ST_ERASE, ST_WRITE, ST_READ: begin
               if (op_expire) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cpu_stall_o <= 1'b0;
      end else if (ce_i) begin
         if (op_start) begin
            cpu_stall_o <= 1'b1;
         end else if (op_expire) begin
            cpu_stall_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control register
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         erase_write_enabled_r   <= 1'b0;
         operation_mode_select_r <= REG_RST[FC0_MODE_HI:FC0_MODE_LO];
         unlock_trigger_r        <= 1'b0;
         write_initiate_r        <= 1'b0;
         read_enable_r           <= 1'b0;
         read_initiate_r         <= 1'b0;
      end else if (ce_i) begin
         // Hardware set wins over a clear in the same cycle
         if (unlock_ok) begin
            erase_write_enabled_r <= 1'b1;
         end else if (wr_fc0 && !reg_wdata_i[FC0_EWEN_BIT]) begin
            erase_write_enabled_r <= 1'b0;
         end
         if (wr_fc0) begin
            operation_mode_select_r <= new_mode;
            read_enable_r           <= reg_wdata_i[FC0_RDEN_BIT];
         end
         if (unlk_start) begin
            unlock_trigger_r <= 1'b1;
         end else if (unlk_expire) begin
            unlock_trigger_r <= 1'b0;
         end
         if (launch_ew) begin
            write_initiate_r <= 1'b1;
         end else if (op_expire && (state_r != ST_READ)) begin
            write_initiate_r <= 1'b0;
         end
         if (launch_rd) begin
            read_initiate_r <= 1'b1;
         end else if (op_expire && (state_r == ST_READ)) begin
            read_initiate_r <= 1'b0;
         end
      end
   end

   // Unlock bytes must all land while the window is open
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         unlk_match_r <= '0;
      end else if (ce_i) begin
         if (unlk_start || !unlk_run) begin
            unlk_match_r <= '0;
         end else if (reg_wr_i && (reg_addr_i > REG_WORD0_DATA_HIGH)
                      && (reg_addr_i <= REG_WORD3_DATA_HIGH)) begin
            unlk_match_r[3'(reg_addr_i - 4'h7)] <=
               (reg_wdata_i == UNLK_PAT[3'(reg_addr_i - REG_WORD0_DATA_LOW)]);
         end
      end
   end

   // Duration select and buffer clear control
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         duration_select_r <= REG_RST[FC2_DUR_BIT];
         buffer_clear_r    <= REG_RST[FC2_CLR_BIT];
      end else if (ce_i) begin
         if (wr_fc2) begin
            duration_select_r <= reg_wdata_i[FC2_DUR_BIT];
         end
         // One cycle to wipe the buffer, then the bit drops
         buffer_clear_r <= wr_fc2 && reg_wdata_i[FC2_CLR_BIT];
      end
   end

   // Chip reset request
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         chip_reset_pattern_r <= REG_RST;
         chip_rst_o           <= 1'b0;
      end else if (ce_i) begin
         chip_rst_o <= 1'b0;
         if (reg_wr_i && idle && (reg_addr_i == REG_CHIP_RESET_PATTERN)) begin
            chip_reset_pattern_r <= reg_wdata_i;
            chip_rst_o           <= (reg_wdata_i == CHIP_RST_KEY);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address and data registers
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flash_word_address_r <= ADDR_RST;
      end else if (ce_i) begin
         if (reg_wr_i && idle && (reg_addr_i == REG_FLASH_ADDRESS_LOW)) begin
            flash_word_address_r[7:0] <= reg_wdata_i;
         end else if (reg_wr_i && idle && (reg_addr_i == REG_FLASH_ADDRESS_HIGH)) begin
            flash_word_address_r[ADDR_W-1:8] <= reg_wdata_i[ADDR_W-9:0];
         end else if (wr_hi0 && erase_write_enabled_r
                      && (flash_word_address_r[4:0] != PAGE_LAST)) begin
            flash_word_address_r <= flash_word_address_r + ADDR_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         data_r <= '{default: REG_RST};
      end else if (ce_i) begin
         if (op_expire && (state_r == ST_READ)) begin
            data_r[0] <= fl_rdata_i[7:0];
            data_r[1] <= fl_rdata_i[15:8];
         end else if (reg_wr_i && idle && (reg_addr_i >= REG_WORD0_DATA_LOW)
                      && (reg_addr_i <= REG_WORD3_DATA_HIGH)) begin
            data_r[3'(reg_addr_i - REG_WORD0_DATA_LOW)] <= reg_wdata_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Page write buffer; tags mark words to program or erase
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tag_r  <= '0;
         wbuf_r <= '{default: WORD_RST};
      end else if (ce_i) begin
         if (buffer_clear_r || (op_expire && (state_r == ST_WRITE))) begin
            tag_r  <= '0;
            wbuf_r <= '{default: WORD_RST};
         end else if (wr_hi0 && erase_write_enabled_r) begin
            wbuf_r[flash_word_address_r[4:0]] <= {reg_wdata_i, data_r[0]};
            tag_r[flash_word_address_r[4:0]]  <= 1'b1;
         end
      end
   end

   // Tagged words go to the array one per cycle at operation start
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stream_on_r  <= 1'b0;
         stream_idx_r <= '0;
         fl_erase_o   <= 1'b0;
         fl_prog_o    <= 1'b0;
         fl_read_o    <= 1'b0;
         fl_addr_o    <= ADDR_RST;
         fl_wdata_o   <= WORD_RST;
      end else if (ce_i) begin
         fl_erase_o <= 1'b0;
         fl_prog_o  <= 1'b0;
         fl_read_o  <= 1'b0;
         if (launch_ew) begin
            stream_on_r  <= 1'b1;
            stream_idx_r <= '0;
         end else if (stream_on_r) begin
            stream_idx_r <= stream_idx_r + 5'h01;
            stream_on_r  <= (stream_idx_r != PAGE_LAST);
            fl_addr_o    <= {flash_word_address_r[ADDR_W-1:5], stream_idx_r};
            fl_wdata_o   <= wbuf_r[stream_idx_r];
            fl_erase_o   <= tag_r[stream_idx_r] && (state_r == ST_ERASE);
            fl_prog_o    <= tag_r[stream_idx_r] && (state_r == ST_WRITE);
         end else if (launch_rd) begin
            fl_addr_o <= flash_word_address_r;
            fl_read_o <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register read port, one cycle latency
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= REG_RST;
      end else if (ce_i && reg_rd_i) begin
         if (reg_addr_i >= REG_WORD0_DATA_LOW && reg_addr_i <= REG_WORD3_DATA_HIGH) begin
            reg_rdata_o <= data_r[3'(reg_addr_i - REG_WORD0_DATA_LOW)];
         end else begin
            unique case (reg_addr_i)
               REG_FLASH_OP_CONTROL:   reg_rdata_o <= {erase_write_enabled_r,
                                                       operation_mode_select_r,
                                                       unlock_trigger_r, write_initiate_r,
                                                       read_enable_r, read_initiate_r};
               REG_CHIP_RESET_PATTERN: reg_rdata_o <= chip_reset_pattern_r;
               REG_FLASH_TIMING:       reg_rdata_o <= {6'h00, duration_select_r,
                                                       buffer_clear_r};
               REG_FLASH_ADDRESS_LOW:  reg_rdata_o <= flash_word_address_r[7:0];
               REG_FLASH_ADDRESS_HIGH: reg_rdata_o <= {3'h0,
                                                       flash_word_address_r[ADDR_W-1:8]};
               default:                reg_rdata_o <= REG_RST;
            endcase
         end
      end
   end

endmodule : iapfp_ctrl

// >>> src/iapfp_pkg.sv
package iapfp_pkg;

   // Core clock
   localparam int CLK_NS = 10;

   // Operation durations, nanoseconds
   localparam int ERASE_T0_NS = 3_200_000;
   localparam int ERASE_T1_NS = 3_700_000;
   localparam int WRITE_T0_NS = 2_200_000;
   localparam int WRITE_T1_NS = 3_000_000;

   // Least times round up to whole cycles
   localparam int ERASE0_CYC = (ERASE_T0_NS + CLK_NS - 1) / CLK_NS;
   localparam int ERASE1_CYC = (ERASE_T1_NS + CLK_NS - 1) / CLK_NS;
   localparam int WRITE0_CYC = (WRITE_T0_NS + CLK_NS - 1) / CLK_NS;
   localparam int WRITE1_CYC = (WRITE_T1_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_CYC   = 4;
   localparam int UNLOCK_CYC = 1000;
   localparam int OP_CNT_W   = 20;
   localparam int UNLK_CNT_W = 16;

   // Register indices on the special register port
   localparam logic [3:0] REG_FLASH_OP_CONTROL   = 4'h0;
   localparam logic [3:0] REG_CHIP_RESET_PATTERN = 4'h1;
   localparam logic [3:0] REG_FLASH_TIMING       = 4'h2;
   localparam logic [3:0] REG_FLASH_ADDRESS_LOW  = 4'h3;
   localparam logic [3:0] REG_FLASH_ADDRESS_HIGH = 4'h4;
   localparam logic [3:0] REG_WORD0_DATA_LOW     = 4'h5;
   localparam logic [3:0] REG_WORD0_DATA_HIGH    = 4'h6;
   localparam logic [3:0] REG_WORD3_DATA_HIGH    = 4'hc;

   // Field positions
   localparam int FC0_EWEN_BIT = 7;
   localparam int FC0_MODE_HI  = 6;
   localparam int FC0_MODE_LO  = 4;
   localparam int FC0_TRIG_BIT = 3;
   localparam int FC0_WI_BIT   = 2;
   localparam int FC0_RDEN_BIT = 1;
   localparam int FC0_RI_BIT   = 0;
   localparam int FC2_DUR_BIT  = 1;
   localparam int FC2_CLR_BIT  = 0;

   // Operation mode codes
   localparam logic [2:0] MODE_WRITE  = 3'h0;
   localparam logic [2:0] MODE_ERASE  = 3'h1;
   localparam logic [2:0] MODE_READ   = 3'h3;
   localparam logic [2:0] MODE_UNLOCK = 3'h6;

   // Reset values
   localparam logic [7:0]  REG_RST   = 8'h00;
   localparam logic [12:0] ADDR_RST  = 13'h0000;
   localparam logic [15:0] WORD_RST  = 16'h0000;

   localparam logic [7:0] CHIP_RST_KEY = 8'h55;
   localparam int         ADDR_W       = 13;
   localparam int         PAGE_WORDS   = 32;
   localparam logic [4:0] PAGE_LAST    = 5'h1f;

   // Unlock bytes, indexed by data register number 0..7 (low/high pairs)
   localparam logic [7:0] UNLK_PAT [8] = '{8'h00, 8'h00, 8'h00, 8'h04,
                                           8'h0d, 8'h09, 8'hc3, 8'h40};

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ERASE = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_READ  = 4'b1000
   } iapfp_state_type;

endpackage : iapfp_pkg

// >>> src/iapfp_timer.sv
`timescale 1ns/1ns
module iapfp_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         ce_i,
   // Control
   input  wire logic         start_i,
   input  wire logic [W-1:0] len_i,
   // Status
   output logic              run_o,
   output logic              expire_o
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_r    <= '0;
         run_o    <= 1'b0;
         expire_o <= 1'b0;
      end else if (ce_i) begin
         expire_o <= 1'b0;
         if (start_i) begin
            cnt_r <= len_i;
            run_o <= 1'b1;
         end else if (run_o) begin
            // Zero length treated as one cycle
            if (cnt_r <= W'(1)) begin
               run_o    <= 1'b0;
               expire_o <= 1'b1;
            end else begin
               cnt_r <= cnt_r - W'(1);
            end
         end
      end
   end
endmodule : iapfp_timer

// >>> tb/iapfp_chk.sv
`timescale 1ns/1ns
module iapfp_chk
   import iapfp_pkg::*;
#(
   parameter int WRITE0_CYCLES = WRITE0_CYC,
   parameter int ERASE1_CYCLES = ERASE1_CYC
) (
   // Watched ports
   input wire logic       core_clk_i,
   input wire logic       sys_rst_i,
   input wire logic       ce_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       fl_erase_o,
   input wire logic       fl_prog_o,
   input wire logic       fl_read_o,
   input wire logic       cpu_stall_o,
   input wire logic       chip_rst_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////////////////////////
   // Stall length, and whether the stall programmed anything
   logic [19:0] stall_cnt_r;
   logic        prog_seen_r;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) stall_cnt_r <= '0;
      else stall_cnt_r <= cpu_stall_o ? stall_cnt_r + 20'h0_0001 : '0;
   end
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) prog_seen_r <= 1'b0;
      else prog_seen_r <= cpu_stall_o && (prog_seen_r || fl_prog_o);
   end
   ////////////////////////////////////////////////////////////
   rst_cause_a: assert property (
      reg_wr_i && ce_i && !cpu_stall_o && reg_addr_i == REG_CHIP_RESET_PATTERN
      && reg_wdata_i == CHIP_RST_KEY |=> chip_rst_o) else $error("chip reset missing");
   rst_single_a: assert property (chip_rst_o |=> !chip_rst_o)
      else $error("chip reset too long");
   unmapped_zero_a: assert property (
      reg_rd_i && ce_i && reg_addr_i > 4'hc |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   addr_high_a: assert property (
      reg_rd_i && ce_i && reg_addr_i == REG_FLASH_ADDRESS_HIGH |=> reg_rdata_o[7:5] == 3'h0)
      else $error("address high upper bits set");
   timing_unused_a: assert property (
      reg_rd_i && ce_i && reg_addr_i == REG_FLASH_TIMING |=> reg_rdata_o[7:2] == 6'h00)
      else $error("timing unused bits set");
   flash_busy_a: assert property (
      fl_prog_o || fl_erase_o || fl_read_o |-> cpu_stall_o) else $error("flash op without stall");
   stall_cause_a: assert property (
      $rose(cpu_stall_o) |-> $past(reg_wr_i) && $past(reg_addr_i) == REG_FLASH_OP_CONTROL)
      else $error("stall without launch");
   read_cause_a: assert property (
      fl_read_o |-> $past(reg_wr_i) && $past(reg_addr_i) == REG_FLASH_OP_CONTROL
      && $past(reg_wdata_i[0]))
      else $error("read without initiate");
   read_end_a: assert property (fl_read_o |-> ##[1:8] !cpu_stall_o)
      else $error("read stall too long");
   dur_max_a: assert property (cpu_stall_o |-> stall_cnt_r <= ERASE1_CYCLES + 40)
      else $error("operation too long");
   dur_min_a: assert property (
      $fell(cpu_stall_o) && prog_seen_r |-> stall_cnt_r >= WRITE0_CYCLES)
      else $error("write too short");
   cover property (fl_prog_o);
   cover property (fl_erase_o);
   cover property (fl_read_o);
   cover property (chip_rst_o);
endmodule : iapfp_chk

bind iapfp_ctrl iapfp_chk #(.WRITE0_CYCLES(WRITE0_CYCLES), .ERASE1_CYCLES(ERASE1_CYCLES))
   u_chk (.core_clk_i, .sys_rst_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
   .reg_rdata_o, .fl_erase_o, .fl_prog_o, .fl_read_o, .cpu_stall_o, .chip_rst_o);

// >>> tb/iapfp_flash_model.sv
`timescale 1ns/1ns
module iapfp_flash_model
   import iapfp_pkg::*;
(
   // Array side of the controller
   input  wire logic              core_clk_i,
   input  wire logic              fl_erase_i,
   input  wire logic              fl_prog_i,
   input  wire logic              fl_read_i,
   input  wire logic [ADDR_W-1:0] fl_addr_i,
   input  wire logic [15:0]       fl_wdata_i,
   output logic      [15:0]       fl_rdata_o
);
   logic [15:0] mem [2**ADDR_W];
   logic [3:0]  hold_r = 4'h0;
   int          prog_cnt = 0;
   // Data holds briefly, then churns so a late sample shows up
   always @(posedge core_clk_i) begin
      if (fl_prog_i) mem[fl_addr_i] <= fl_wdata_i;
      if (fl_prog_i) prog_cnt <= prog_cnt + 1;
      if (fl_erase_i) mem[fl_addr_i] <= 16'h0000;
      if (fl_read_i) begin
         fl_rdata_o <= mem[fl_addr_i];
         hold_r <= 4'h8;
      end else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
      else fl_rdata_o <= ~fl_rdata_o;
   end
endmodule : iapfp_flash_model

// >>> tb/iap_flash_program_control_tb.sv
`timescale 1ns/1ns
module iap_flash_program_control_tb;
   import iapfp_pkg::*;
   localparam int E0C = 40;
   localparam int W1C = 45;
   logic              core_clk_i  = 1'b0;
   logic              sys_rst_i   = 1'b1;
   logic              ce_i        = 1'b1;
   logic [3:0]        reg_addr_i  = 4'h0;
   logic              reg_wr_i    = 1'b0;
   logic              reg_rd_i    = 1'b0;
   logic [7:0]        reg_wdata_i = 8'h00;
   logic [7:0]        reg_rdata_o;
   logic              fl_erase_o;
   logic              fl_prog_o;
   logic              fl_read_o;
   logic [ADDR_W-1:0] fl_addr_o;
   logic [15:0]       fl_wdata_o;
   logic [15:0]       fl_rdata_i;
   logic              cpu_stall_o;
   logic              chip_rst_o;
   int                bad_count = 0;
   int                checks = 0;
   int                n;
   always #5 core_clk_i = ~core_clk_i;
   iapfp_ctrl #(.ERASE0_CYCLES(E0C), .ERASE1_CYCLES(50), .WRITE0_CYCLES(36),
      .WRITE1_CYCLES(W1C), .READ_CYCLES(4), .UNLOCK_CYCLES(20)) u_dut (.core_clk_i,
      .sys_rst_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
      .fl_erase_o, .fl_prog_o, .fl_read_o, .fl_addr_o, .fl_wdata_o, .fl_rdata_i,
      .cpu_stall_o, .chip_rst_o);
   iapfp_flash_model u_flash (.core_clk_i, .fl_erase_i(fl_erase_o), .fl_prog_i(fl_prog_o),
      .fl_read_i(fl_read_o), .fl_addr_i(fl_addr_o), .fl_wdata_i(fl_wdata_o),
      .fl_rdata_o(fl_rdata_i));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      #1 chk(what, {8'h00, exp}, {8'h00, reg_rdata_o});
   endtask : rd
   // Bounded wait so a stuck stall ends the run cleanly
   task automatic op_wait(input int lo, input string what);
      n = 0;
      #1;
      while (cpu_stall_o === 1'b1 && n < 2000) begin
         @(posedge core_clk_i);
         #1 n++;
      end
      chk(what, 16'h0001, 16'((n >= lo) && (n <= lo + 2)));
   endtask : op_wait
   task automatic unlock(input logic ok);
      logic [7:0] pat [6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
      wr(REG_FLASH_OP_CONTROL, 8'h68);
      rd(REG_FLASH_OP_CONTROL, 8'h68, "unlock trigger");
      for (int i = 0; i < 6; i++) wr(4'(7 + i), (i == 5 && !ok) ? 8'h41 : pat[i]);
      repeat (20) @(posedge core_clk_i);
      rd(REG_FLASH_OP_CONTROL, ok ? 8'he0 : 8'h60, "unlock result");
   endtask : unlock
   task automatic reg_basics();
      rd(REG_FLASH_OP_CONTROL, 8'h00, "op reset");
      rd(4'hd, 8'h00, "unmapped");
      wr(REG_FLASH_ADDRESS_HIGH, 8'hff);
      rd(REG_FLASH_ADDRESS_HIGH, 8'h1f, "address high");
      wr(REG_FLASH_TIMING, 8'hfe);
      rd(REG_FLASH_TIMING, 8'h02, "timing");
      wr(REG_FLASH_OP_CONTROL, 8'h80);
      rd(REG_FLASH_OP_CONTROL, 8'h00, "enable by software");
   endtask : reg_basics
   task automatic load_page();
      wr(REG_WORD0_DATA_HIGH, 8'hee);
      wr(REG_FLASH_TIMING, 8'h03);
      rd(REG_FLASH_TIMING, 8'h02, "buffer clear");
      wr(REG_FLASH_ADDRESS_HIGH, 8'h01);
      wr(REG_FLASH_ADDRESS_LOW, 8'h3e);
      wr(REG_WORD0_DATA_LOW, 8'h34);
      rd(REG_FLASH_ADDRESS_LOW, 8'h3e, "low byte only");
      wr(REG_WORD0_DATA_HIGH, 8'h12);
      rd(REG_FLASH_ADDRESS_LOW, 8'h3f, "increment");
      wr(REG_WORD0_DATA_LOW, 8'h78);
      wr(REG_WORD0_DATA_HIGH, 8'h56);
      rd(REG_FLASH_ADDRESS_LOW, 8'h3f, "page end");
   endtask : load_page
   task automatic write_page();
      wr(REG_FLASH_OP_CONTROL, 8'h84);
      op_wait(W1C, "write time");
      rd(REG_FLASH_OP_CONTROL, 8'h80, "write done");
      chk("word 30", 16'h1234, u_flash.mem[13'h013e]);
      chk("word 31", 16'h5678, u_flash.mem[13'h013f]);
      chk("program count", 16'h0002, 16'(u_flash.prog_cnt));
   endtask : write_page
   task automatic read_word();
      wr(REG_FLASH_OP_CONTROL, 8'hb2);
      wr(REG_FLASH_OP_CONTROL, 8'hb3);
      op_wait(4, "read time");
      rd(REG_WORD0_DATA_LOW, 8'h78, "read low");
      rd(REG_WORD0_DATA_HIGH, 8'h56, "read high");
      rd(REG_FLASH_OP_CONTROL, 8'hb2, "read done");
      wr(REG_FLASH_OP_CONTROL, 8'hb0);
      wr(REG_FLASH_OP_CONTROL, 8'hb1);
      #1 chk("read inhibited", 16'h0000, {15'h0000, cpu_stall_o});
   endtask : read_word
   task automatic lock_and_erase();
      wr(REG_FLASH_OP_CONTROL, 8'h00);
      wr(REG_FLASH_OP_CONTROL, 8'h04);
      #1 chk("write locked", 16'h0000, {15'h0000, cpu_stall_o});
      unlock(1'b1);
      wr(REG_FLASH_TIMING, 8'h00);
      wr(REG_WORD0_DATA_HIGH, 8'hff);
      wr(REG_FLASH_OP_CONTROL, 8'h94);
      // Freeze mid-erase; the stall must stretch by the same span
      ce_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      ce_i <= 1'b1;
      op_wait(E0C, "erase time");
      chk("erased", 16'h0000, u_flash.mem[13'h013f]);
      chk("untagged kept", 16'h1234, u_flash.mem[13'h013e]);
   endtask : lock_and_erase
   task automatic chip_reset();
      wr(REG_CHIP_RESET_PATTERN, 8'h54);
      #1 chk("no chip reset", 16'h0000, {15'h0000, chip_rst_o});
      wr(REG_CHIP_RESET_PATTERN, 8'h55);
      #1 chk("chip reset", 16'h0001, {15'h0000, chip_rst_o});
   endtask : chip_reset
   task automatic complete_run();
      if (bad_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      reg_basics();
      unlock(1'b0);
      unlock(1'b1);
      load_page();
      write_page();
      read_word();
      lock_and_erase();
      chip_reset();
      complete_run();
   end
   // Whole run is near 300 cycles
   initial begin
      repeat (6000) @(posedge core_clk_i);
      bad_count++;
      complete_run();
   end
endmodule : iap_flash_program_control_tb
